// file: src/avs_pkg.sv
// Purpose: shared constants for the analog value substitution block
// Assumes: 16-bit process words, 12-bit magnitude plus sign from the converters
// Notes: constants only; no logic lives here
//
// How it works
// - every driven word depends on master state and field supply; reported words depend on supply only
// - after power-on or new parameters each input reports 7FFF until first conversion
// - after startup each output drives zero in RUN until the first value is output
// - in master STOP each output follows its stop reaction, not new values
// - with field supply absent each input reports 7FFF in any master state
// - inputs in nominal, over- or underrange report the measured value unchanged
// - input overflow reports 7FFF, input underflow reports 8000
// - until valid measured values exist an input reports 7FFF
// - outputs in nominal, over- or underrange drive the master value exactly
// - output values in overflow or underflow are replaced by zero
// - before parameter assignment an output drives zero
// - converter results carry twelve bits of magnitude plus a sign
// - four independent input channels, each with its own substitution
package avs_pkg;

  // ==========================================================
  // word formats
  localparam int WORD_W = 16;
  localparam int MAG_W = 12;
  localparam int MAG_SHIFT = 3;
  localparam logic [15:0] CODE_OVERFLOW = 16'h7FFF;
  localparam logic [15:0] CODE_UNDERFLOW = 16'h8000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;

  // ==========================================================
  // channel counts and output range limits
  localparam int AI_CHANNELS = 4;
  localparam int AO_CHANNELS = 4;
  localparam logic [15:0] AO_HIGH_LIMIT = 16'h7EFF;
  localparam logic [15:0] AO_LOW_LIMIT = 16'h8100;

  // ==========================================================
  // reset values and synchroniser depth
  localparam logic RST_FLAG = 1'b0;
  localparam logic [15:0] RST_AI_WORD = 16'h7FFF;
  localparam logic [15:0] RST_AO_WORD = 16'h0000;
  localparam int SYNC_STAGES = 2;

  // output channel states
  typedef enum logic [1:0] {
    AO_UNASSIGNED,
    AO_WAIT_FIRST,
    AO_RUNNING,
    AO_STOPPED
  } ao_state_t;

endpackage

// file: src/ai_conv_if.sv
// Purpose: carries one converter result and the station state to an input channel
// Assumes: all signals on the station clock
// Notes: one instance per input channel
`timescale 1ns/1ps
`default_nettype none
interface ai_conv_if;
  logic conv_valid;
  logic conv_sign;
  logic [11:0] conv_mag;
  logic conv_ovf;
  logic conv_udf;
  logic param_load;
  logic supply_ok;
  logic [15:0] word;
  logic valid;

  // the top drives the converter side and reads the result
  modport top (
    output conv_valid, conv_sign, conv_mag, conv_ovf, conv_udf,
    output param_load, supply_ok,
    input word, valid
  );
  modport chan (
    input conv_valid, conv_sign, conv_mag, conv_ovf, conv_udf,
    input param_load, supply_ok,
    output word, valid
  );
endinterface
`default_nettype wire

// file: src/ai_channel.sv
// Purpose: substitution and range evaluation for one analog input channel
// Assumes: supply_ok already synchronised; conv_valid a one-cycle pulse
// Notes: word and valid are flip-flops
`timescale 1ns/1ps
`default_nettype none
module ai_channel (
  input wire logic clk,
  input wire logic rst_n,
  ai_conv_if.chan bus
);

  // ==========================================================
  // conversion to 16-bit two's complement
  logic [15:0] scaled;
  logic [15:0] measured;
  logic [15:0] ranged;
  logic next_valid;
  logic [15:0] next_word;

  // magnitude is scaled left so full scale lands near the word's top
  assign scaled = {1'b0, bus.conv_mag, {avs_pkg::MAG_SHIFT{1'b0}}};
  assign measured = bus.conv_sign ? 16'(~scaled + 16'h0001) : scaled;
  // overflow wins over underflow if the converter ever flags both
  assign ranged = bus.conv_ovf ? avs_pkg::CODE_OVERFLOW :
                  bus.conv_udf ? avs_pkg::CODE_UNDERFLOW :
                  measured;

  // a fresh result wins over a parameter load in the same cycle
  assign next_valid = bus.conv_valid ? 1'b1 :
                      bus.param_load ? 1'b0 : bus.valid;

  // missing supply masks everything, then missing first result
  assign next_word = !bus.supply_ok ? avs_pkg::CODE_OVERFLOW :
                     bus.conv_valid ? ranged :
                     !next_valid ? avs_pkg::CODE_OVERFLOW :
                     bus.word;

  // ==========================================================
  // result registers; last value is kept between conversions
  logic [15:0] held;
  logic [15:0] next_held;
  assign next_held = bus.conv_valid ? ranged : held;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.valid <= avs_pkg::RST_FLAG;
      held <= avs_pkg::RST_AI_WORD;
      bus.word <= avs_pkg::RST_AI_WORD;
    end else begin
      bus.valid <= next_valid;
      held <= next_held;
      bus.word <= (bus.supply_ok && next_valid) ? next_held : next_word;
    end
  end

endmodule
`default_nettype wire

// file: src/analog_value_substitution.sv
// Purpose: picks the word each analog input reports and each analog output drives
// Assumes: master state and values come from logic on clk; field supply is a pin
// Notes: all outputs are flip-flops; vectors pack channel 0 in the low bits
`timescale 1ns/1ps
`default_nettype none
module analog_value_substitution #(
  parameter int AI_CH = avs_pkg::AI_CHANNELS,
  parameter int AO_CH = avs_pkg::AO_CHANNELS,
  parameter logic [15:0] AO_HIGH = avs_pkg::AO_HIGH_LIMIT,
  parameter logic [15:0] AO_LOW = avs_pkg::AO_LOW_LIMIT
) (
  input wire logic clk,
  input wire logic rst_n,
  // station state
  input wire logic master_run,
  input wire logic field_supply_pin,
  // converter results, one slice per input channel
  input wire logic [AI_CH-1:0] conv_valid,
  input wire logic [AI_CH-1:0] conv_sign,
  input wire logic [AI_CH*12-1:0] conv_mag,
  input wire logic [AI_CH-1:0] conv_ovf,
  input wire logic [AI_CH-1:0] conv_udf,
  input wire logic [AI_CH-1:0] ai_param_load,
  // process image words towards the master
  output logic [AI_CH*16-1:0] ai_word,
  output logic [AI_CH-1:0] ai_valid,
  // output channel values and parameters from the master
  input wire logic [AO_CH*16-1:0] ao_value,
  input wire logic [AO_CH-1:0] ao_strobe,
  input wire logic [AO_CH-1:0] ao_param_done,
  input wire logic [AO_CH-1:0] ao_stop_hold,
  input wire logic [AO_CH*16-1:0] ao_subst,
  // values towards the output converters
  output logic [AO_CH*16-1:0] ao_drive,
  output logic [AO_CH-1:0] ao_first_done,
  output logic supply_ok
);

  // ==========================================================
  // field supply synchroniser
  // the pin is asynchronous to clk; stage 0 feeds only stage 1
  logic [avs_pkg::SYNC_STAGES-1:0] supply_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_sync <= '0;
    end else begin
      supply_sync <= {supply_sync[0], field_supply_pin};
    end
  end

  // registered copy so the status output is a flip-flop
  logic supply_now;
  assign supply_now = supply_sync[avs_pkg::SYNC_STAGES-1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_ok <= avs_pkg::RST_FLAG;
    end else begin
      supply_ok <= supply_now;
    end
  end

  // ==========================================================
  // input channels
  // each channel runs its own substitution; nothing is shared
  // but the supply level, so one channel's fault never masks another
  genvar gi;
  generate
    for (gi = 0; gi < AI_CH; gi++) begin : g_ai
      ai_conv_if link ();

      // converter slice for this channel
      assign link.conv_valid = conv_valid[gi];
      assign link.conv_sign = conv_sign[gi];
      assign link.conv_mag = conv_mag[gi*12 +: 12];
      assign link.conv_ovf = conv_ovf[gi];
      assign link.conv_udf = conv_udf[gi];
      assign link.param_load = ai_param_load[gi];
      // master state has no say on inputs; only supply does
      assign link.supply_ok = supply_now;

      ai_channel u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .bus(link)
      );

      // channel words are flip-flops inside the channel
      assign ai_word[gi*16 +: 16] = link.word;
      assign ai_valid[gi] = link.valid;
    end
  endgenerate

  // ==========================================================
  // output channels
  genvar go;
  generate
    for (go = 0; go < AO_CH; go++) begin : g_ao
      avs_pkg::ao_state_t state;
      avs_pkg::ao_state_t next_state;
      logic [15:0] value;
      logic [15:0] subst;
      logic [15:0] drive;
      logic [15:0] next_drive;
      logic first;
      logic next_first;
      logic too_high;
      logic too_low;
      logic out_of_range;
      logic [15:0] ranged;
      logic take;

      // ------------------------------------------------------
      // range decode on the master's value
      // signed compare: above the high limit or below the low one
      assign value = ao_value[go*16 +: 16];
      assign subst = ao_subst[go*16 +: 16];
      assign too_high = $signed(value) > $signed(AO_HIGH);
      assign too_low = $signed(value) < $signed(AO_LOW);
      assign out_of_range = too_high | too_low;
      // overflow and underflow give zero; the rest pass exactly
      assign ranged = out_of_range ? avs_pkg::CODE_ZERO : value;

      // a value counts only in RUN with supply and parameters
      assign take = ao_strobe[go] & master_run & supply_now & ao_param_done[go];

      // ------------------------------------------------------
      // state selection
      // parameters are checked first: losing them drops the channel
      // to UNASSIGNED whatever it was doing; supply is checked only through take
      always_comb begin
        next_state = state;
        unique case (state)
          avs_pkg::AO_UNASSIGNED: begin
            if (ao_param_done[go]) begin
              next_state = avs_pkg::AO_WAIT_FIRST;
            end
          end
          avs_pkg::AO_WAIT_FIRST: begin
            if (!ao_param_done[go]) begin
              next_state = avs_pkg::AO_UNASSIGNED;
            end else if (!master_run) begin
              next_state = avs_pkg::AO_STOPPED;
            end else if (take) begin
              next_state = avs_pkg::AO_RUNNING;
            end
          end
          avs_pkg::AO_RUNNING: begin
            if (!ao_param_done[go]) begin
              next_state = avs_pkg::AO_UNASSIGNED;
            end else if (!master_run) begin
              next_state = avs_pkg::AO_STOPPED;
            end
          end
          avs_pkg::AO_STOPPED: begin
            if (!ao_param_done[go]) begin
              next_state = avs_pkg::AO_UNASSIGNED;
            end else if (master_run) begin
              // to RUNNING if a value was taken, keeping the last word until a new one; else back to waiting
              next_state = first ? avs_pkg::AO_RUNNING : avs_pkg::AO_WAIT_FIRST;
            end
          end
        endcase
      end

      // ------------------------------------------------------
      // drive selection
      // without supply the converter is unpowered; zero keeps
      // the register from replaying a stale word when it returns
      always_comb begin
        next_drive = drive;
        next_first = first;
        if (!ao_param_done[go]) begin
          next_drive = avs_pkg::CODE_ZERO;
          next_first = 1'b0;
        end else if (!supply_now) begin
          next_drive = avs_pkg::CODE_ZERO;
        end else if (!master_run) begin
          // hold keeps the present word, else the substitute
          next_drive = ao_stop_hold[go] ? drive : subst;
        end else if (take) begin
          next_drive = ranged;
          next_first = 1'b1;
        end else if (!first) begin
          next_drive = avs_pkg::CODE_ZERO;
        end
      end

      // ------------------------------------------------------
      // channel registers
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          state <= avs_pkg::AO_UNASSIGNED;
          drive <= avs_pkg::RST_AO_WORD;
          first <= avs_pkg::RST_FLAG;
        end else begin
          state <= next_state;
          drive <= next_drive;
          first <= next_first;
        end
      end

      assign ao_drive[go*16 +: 16] = drive;
      assign ao_first_done[go] = first;
    end
  endgenerate

endmodule
`default_nettype wire

// file: bench/avs_monitor.sv
// Purpose: port checker for the value substitution block
// Assumes: channel 0 stands in for its siblings
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module avs_monitor #(
  parameter int AI_CH = 4,
  parameter int AO_CH = 4,
  parameter logic [15:0] AO_HIGH = 16'h7EFF,
  parameter logic [15:0] AO_LOW = 16'h8100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_run,
  input wire logic [AI_CH-1:0] conv_valid,
  input wire logic [AI_CH-1:0] conv_sign,
  input wire logic [AI_CH*12-1:0] conv_mag,
  input wire logic [AI_CH-1:0] conv_ovf,
  input wire logic [AI_CH-1:0] conv_udf,
  input wire logic [AI_CH-1:0] ai_param_load,
  input wire logic [AI_CH*16-1:0] ai_word,
  input wire logic [AI_CH-1:0] ai_valid,
  input wire logic [AO_CH*16-1:0] ao_value,
  input wire logic [AO_CH-1:0] ao_strobe,
  input wire logic [AO_CH-1:0] ao_param_done,
  input wire logic [AO_CH-1:0] ao_stop_hold,
  input wire logic [AO_CH*16-1:0] ao_subst,
  input wire logic [AO_CH*16-1:0] ao_drive,
  input wire logic [AO_CH-1:0] ao_first_done,
  input wire logic supply_ok
);
  // ==========================================
  // channel 0 helpers
  wire logic [15:0] mag0 = {1'b0, conv_mag[11:0], 3'h0};
  wire logic [15:0] meas0 = conv_sign[0] ? -mag0 : mag0;
  wire logic take0 = ao_strobe[0] && master_run && supply_ok && ao_param_done[0];
  wire logic hi0 = $signed(ao_value[15:0]) <= $signed(AO_HIGH);
  wire logic fits0 = hi0 && ($signed(ao_value[15:0]) >= $signed(AO_LOW));
  wire logic stop0 = !master_run && ao_param_done[0] && supply_ok;
  wire logic newc0 = conv_valid[0] && !ai_param_load[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_fresh;
    !ao_param_done[0] ##1 (ao_param_done[0] && master_run && !ao_strobe[0]);
  endsequence
  sequence s_pass;
    take0 && fits0;
  endsequence
  property p_ovf; newc0 && conv_ovf[0] |=> ai_word[15:0] == 16'h7FFF; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow word wrong");
  property p_udf;
    newc0 && conv_udf[0] && !conv_ovf[0] |=> !supply_ok || ai_word[15:0] == 16'h8000;
  endproperty
  a_udf: assert property (p_udf) else $error("underflow word wrong");
  property p_meas;
    newc0 && !conv_ovf[0] && !conv_udf[0] |=> !supply_ok || ai_word[15:0] == $past(meas0);
  endproperty
  a_meas: assert property (p_meas) else $error("measured word wrong");
  property p_dead; !supply_ok |-> ai_word[15:0] == 16'h7FFF; endproperty
  a_dead: assert property (p_dead) else $error("word without supply");
  property p_load;
    ai_param_load[0] && !conv_valid[0] |=> !ai_valid[0] && ai_word[15:0] == 16'h7FFF;
  endproperty
  a_load: assert property (p_load) else $error("word after load");
  property p_inval; !ai_valid[0] |-> ai_word[15:0] == 16'h7FFF; endproperty
  a_inval: assert property (p_inval) else $error("invalid word");
  property p_unset;
    !ao_param_done[0] |=> ao_drive[15:0] == 16'h0000 && !ao_first_done[0];
  endproperty
  a_unset: assert property (p_unset) else $error("drive before params");
  property p_start; s_fresh |=> ao_drive[15:0] == 16'h0000 && !ao_first_done[0]; endproperty
  a_start: assert property (p_start) else $error("drive at startup");
  // supply_ok lags the internal supply level by one edge, so a drop may land in between
  property p_pass;
    s_pass |=> !supply_ok || (ao_drive[15:0] == $past(ao_value[15:0]) && ao_first_done[0]);
  endproperty
  a_pass: assert property (p_pass) else $error("value not passed");
  property p_clip; take0 && !fits0 |=> ao_drive[15:0] == 16'h0000; endproperty
  a_clip: assert property (p_clip) else $error("value not cleared");
  property p_sub;
    stop0 && !ao_stop_hold[0] |=> !supply_ok || ao_drive[15:0] == $past(ao_subst[15:0]);
  endproperty
  a_sub: assert property (p_sub) else $error("stop substitute");
  property p_hold;
    stop0 && ao_stop_hold[0] |=> !supply_ok || $stable(ao_drive[15:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("stop hold");
  // status and drive flops update on the same edge, so the check is same-cycle
  property p_nosup; !supply_ok |-> ao_drive[15:0] == 16'h0000; endproperty
  a_nosup: assert property (p_nosup) else $error("drive without supply");
endmodule
bind analog_value_substitution avs_monitor #(.AI_CH(AI_CH), .AO_CH(AO_CH),
  .AO_HIGH(AO_HIGH), .AO_LOW(AO_LOW)) avs_monitor_inst (.clk(clk), .rst_n(rst_n),
  .master_run(master_run), .conv_valid(conv_valid), .conv_sign(conv_sign),
  .conv_mag(conv_mag), .conv_ovf(conv_ovf), .conv_udf(conv_udf),
  .ai_param_load(ai_param_load), .ai_word(ai_word), .ai_valid(ai_valid),
  .ao_value(ao_value), .ao_strobe(ao_strobe), .ao_param_done(ao_param_done),
  .ao_stop_hold(ao_stop_hold), .ao_subst(ao_subst), .ao_drive(ao_drive),
  .ao_first_done(ao_first_done), .supply_ok(supply_ok));
`default_nettype wire

// file: bench/master_model.sv
// Purpose: fieldbus master side of the output channels
// Assumes: driven 1 ns after the rising edge
// Notes: released value lines show the inverse word
`timescale 1ns/1ps
`default_nettype none
module master_model (
  input wire logic clk,
  output logic master_run,
  output logic [63:0] ao_value,
  output logic [3:0] ao_strobe,
  output logic [3:0] ao_param_done,
  output logic [3:0] ao_stop_hold,
  output logic [63:0] ao_subst
);
  // ==========================================
  // idle master: stopped, nothing assigned
  initial begin
    master_run = 1'b0;
    ao_value = 64'h0;
    ao_strobe = 4'h0;
    mode(1'b0, 4'h0, 4'h0, 16'h0000);
  end
  // state change; substitute shared by all channels
  task automatic mode(input logic run, input logic [3:0] pd, input logic [3:0] hold,
                      input logic [15:0] sub);
    master_run = run;
    ao_param_done = pd;
    ao_stop_hold = hold;
    ao_subst = {4{sub}};
  endtask
  // one-cycle strobe, lines flipped so a stale word cannot pass
  task automatic put(input int ch, input logic [15:0] v);
    @(posedge clk);
    #1;
    ao_value[ch*16+:16] = v;
    ao_strobe[ch] = 1'b1;
    @(posedge clk);
    #1;
    ao_strobe[ch] = 1'b0;
    ao_value[ch*16+:16] = ~v;
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench for value substitution
// Assumes: outputs registered one edge after the sampling edge
// Notes: waits of four edges cover the supply synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, field_supply_pin, master_run, supply_ok;
  logic [3:0] conv_valid, conv_sign, conv_ovf, conv_udf, ai_param_load, ai_valid;
  logic [3:0] ao_strobe, ao_param_done, ao_stop_hold, ao_first_done;
  logic [47:0] conv_mag;
  logic [63:0] ai_word, ao_value, ao_subst, ao_drive;
  logic [11:0] mags [4] = '{12'hFFF, 12'h001, 12'h800, 12'h000};
  logic [15:0] av [5] = '{16'h0100, avs_pkg::AO_HIGH_LIMIT, 16'h7F00,
                          avs_pkg::AO_LOW_LIMIT, 16'h80FF};
  logic [15:0] ae [5] = '{16'h0100, avs_pkg::AO_HIGH_LIMIT, 16'h0000,
                          avs_pkg::AO_LOW_LIMIT, 16'h0000};
  int n_fail = 0;
  int n_checks = 0;
  analog_value_substitution analog_value_substitution_inst (.clk(clk), .rst_n(rst_n),
    .master_run(master_run), .field_supply_pin(field_supply_pin), .conv_valid(conv_valid),
    .conv_sign(conv_sign), .conv_mag(conv_mag), .conv_ovf(conv_ovf), .conv_udf(conv_udf),
    .ai_param_load(ai_param_load), .ai_word(ai_word), .ai_valid(ai_valid),
    .ao_value(ao_value), .ao_strobe(ao_strobe), .ao_param_done(ao_param_done),
    .ao_stop_hold(ao_stop_hold), .ao_subst(ao_subst), .ao_drive(ao_drive),
    .ao_first_done(ao_first_done), .supply_ok(supply_ok));
  master_model master_model_inst (.clk(clk), .master_run(master_run), .ao_value(ao_value),
    .ao_strobe(ao_strobe), .ao_param_done(ao_param_done), .ao_stop_hold(ao_stop_hold),
    .ao_subst(ao_subst));
  // ==========================================
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  function automatic logic [15:0] scl(input logic s, input logic [11:0] m);
    scl = s ? -{1'b0, m, 3'h0} : {1'b0, m, 3'h0};
  endfunction
  // one conversion pulse, then one edge for the word to settle
  task automatic conv(input int ch, input logic s, input logic [11:0] m,
                      input logic o, input logic u);
    @(posedge clk);
    #1;
    conv_valid[ch] = 1'b1;
    conv_sign[ch] = s;
    conv_mag[ch*12+:12] = m;
    conv_ovf[ch] = o;
    conv_udf[ch] = u;
    w(1);
    conv_valid[ch] = 1'b0;
    conv_mag[ch*12+:12] = ~m;
    w(1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    {conv_valid, conv_sign, conv_ovf, conv_udf, ai_param_load} = 20'h0;
    conv_mag = 48'h0;
    field_supply_pin = 1'b1;
    rst_n = 1'b0;
    w(2);
    rst_n = 1'b1;
    w(4);
    for (int c = 0; c < 4; c++) chk("ai_word", 16'h7FFF, ai_word[c*16+:16]);
    chk("ai_valid", 16'h0000, {12'h0, ai_valid});
    for (int c = 0; c < 4; c++) begin
      conv(c, c[0], mags[c], 1'b0, 1'b0);
      chk("ai_word", scl(c[0], mags[c]), ai_word[c*16+:16]);
    end
    conv(0, 1'b0, 12'h123, 1'b1, 1'b0);
    chk("ai_word", 16'h7FFF, ai_word[15:0]);
    conv(0, 1'b1, 12'h123, 1'b0, 1'b1);
    chk("ai_word", 16'h8000, ai_word[15:0]);
    ai_param_load[0] = 1'b1;
    w(1);
    ai_param_load[0] = 1'b0;
    w(1);
    chk("ai_word", 16'h7FFF, ai_word[15:0]);
    chk("ai_valid", 16'h000E, {12'h0, ai_valid});
    master_model_inst.mode(1'b1, 4'h1, 4'h0, 16'h1234);
    w(2);
    chk("ao_drive", 16'h0000, ao_drive[15:0]);
    for (int i = 0; i < 5; i++) begin
      master_model_inst.put(0, av[i]);
      w(1);
      chk("ao_drive", ae[i], ao_drive[15:0]);
    end
    chk("ao_first_done", 16'h0001, {15'h0, ao_first_done[0]});
    master_model_inst.put(0, 16'h0200);
    master_model_inst.mode(1'b0, 4'h1, 4'h1, 16'h1234);
    master_model_inst.put(0, 16'h0555);
    w(1);
    chk("ao_drive", 16'h0200, ao_drive[15:0]);
    master_model_inst.mode(1'b0, 4'h1, 4'h0, 16'h1234);
    w(2);
    chk("ao_drive", 16'h1234, ao_drive[15:0]);
    field_supply_pin = 1'b0;
    w(4);
    chk("supply_ok", 16'h0000, {15'h0, supply_ok});
    chk("ao_drive", 16'h0000, ao_drive[15:0]);
    conv(1, 1'b0, 12'h00A, 1'b0, 1'b0);
    chk("ai_word", 16'h7FFF, ai_word[31:16]);
    field_supply_pin = 1'b1;
    w(4);
    chk("ai_word", scl(1'b0, 12'h00A), ai_word[31:16]);
    // still in STOP, so the substitute comes back with the supply
    chk("ao_drive", 16'h1234, ao_drive[15:0]);
    master_model_inst.mode(1'b1, 4'h0, 4'h0, 16'h1234);
    w(2);
    chk("ao_drive", 16'h0000, ao_drive[15:0]);
    chk("ao_first_done", 16'h0000, {15'h0, ao_first_done[0]});
    // channels 1 to 3 never got parameters
    for (int c = 1; c < 4; c++) chk("ao_drive", 16'h0000, ao_drive[c*16+:16]);
    chk("ao_first_done", 16'h0000, {12'h0, ao_first_done});
    finish_test();
  end
endmodule
`default_nettype wire
